// ==== verilog/swl_device.sv ====
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Power-of-two DEPTH only: pointers wrap by overflow
module swl_fifo #(
	parameter int W     = 10,
	parameter int DEPTH = 16
) (
	input  wire logic         core_clk_in, // Clock
	input  wire logic         rst_in,      // Async reset
	input  wire logic         in_valid_in, // Write request
	input  wire logic [W-1:0] in_data_in,  // Write data
	output logic              in_ready_out, // Not full
	output logic              out_valid_out, // Not empty
	output logic      [W-1:0] out_data_out, // Head word
	input  wire logic         out_ready_in  // Pop
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0]   cnt;
	logic [AW:0]   next_cnt;
	logic          push;
	logic          pop;

	assign push = in_valid_in && in_ready_out;
	assign pop  = out_valid_out && out_ready_in;
	assign next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data_out = mem[rp];

	always_ff @(posedge core_clk_in) begin
		if (push) begin
			mem[wp] <= in_data_in;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
			in_ready_out <= 1'b1;
			out_valid_out <= 1'b0;
		end else begin
			wp <= wp + AW'(push);
			rp <= rp + AW'(pop);
			cnt <= next_cnt;
			in_ready_out <= next_cnt != (AW+1)'(DEPTH);
			out_valid_out <= next_cnt != '0;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module swl_device #(
	parameter int RSTL_CYC = swl_pkg::RESET_LOW_CYC,
	parameter int POR_CYC  = swl_pkg::POR_LOW_CYC,
	parameter int DEPTH    = 16
) (
	input  wire logic              core_clk_in,   // 10 MHz clock
	input  wire logic              rst_in,        // Async reset
	swl_if.device                  link,          // Single-wire line
	input  wire logic              tx_valid_in,   // Byte to send
	input  wire swl_pkg::swl_kind_t tx_kind_in,   // Data or check
	input  wire logic        [7:0] tx_data_in,    // Data byte
	output logic                   tx_ready_out,  // Queue has room
	output logic                   rx_valid_out,  // Byte received
	output logic             [7:0] rx_data_out,   // Received byte
	input  wire logic              crc16_clear_in, // Clear generator
	input  wire logic              crc16_load_in, // Load address
	input  wire logic       [15:0] crc16_load_val_in, // Address value
	input  wire logic              crc8_clear_in, // Clear id check
	input  wire swl_pkg::swl_chk_t chk_sel_in,    // Channel check
	output logic                   prog_strobe_out, // Program pulse
	output logic             [7:0] prog_data_out, // Scratch byte
	output logic                   por_out,       // Long low seen
	output logic            [15:0] crc16_out,     // Generator state
	output logic             [7:0] crc8_out       // Id check state
);
	import swl_pkg::*;

	typedef enum logic [1:0] {
		D_IDLE  = 2'b00,
		D_SLOT  = 2'b01,
		D_PWAIT = 2'b10,
		D_PLOW  = 2'b11
	} swl_dst_t;

	swl_dst_t    state;
	logic        ln_s1, ln_s2, ln_q;
	logic        vp_s1, vp_s2, vp_q;
	logic [15:0] low_cnt;
	logic [15:0] tmr;
	logic [4:0]  bitcnt;
	logic        txbusy;
	logic        txchk;
	logic [4:0]  txlen;
	logic [15:0] txsh;
	logic [7:0]  rxsh;
	logic        pend_chk;
	logic [5:0]  blkcnt;
	logic [5:0]  blk_n;
	logic        f_valid;
	logic [9:0]  f_data;
	logic        f_pop;
	logic        fall, rise, bit_evt, cur_bit, hash_bit;
	logic        byte_end, data_end, chk_sent, por_hit, load_now;

	swl_fifo #(.W(10), .DEPTH(DEPTH)) u_txq (
		.core_clk_in  (core_clk_in),
		.rst_in       (rst_in),
		.in_valid_in  (tx_valid_in),
		.in_data_in   ({tx_kind_in, tx_data_in}),
		.in_ready_out (tx_ready_out),
		.out_valid_out(f_valid),
		.out_data_out (f_data),
		.out_ready_in (f_pop)
	);

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ln_s1 <= 1'b1;
			ln_s2 <= 1'b1;
			ln_q  <= 1'b1;
			vp_s1 <= 1'b0;
			vp_s2 <= 1'b0;
			vp_q  <= 1'b0;
		end else begin
			ln_s1 <= link.line;
			ln_s2 <= ln_s1;
			ln_q  <= ln_s2;
			vp_s1 <= link.vpp;
			vp_s2 <= vp_s1;
			vp_q  <= vp_s2;
		end
	end

	assign fall = ln_q && !ln_s2;
	assign rise = !ln_q && ln_s2;
	assign bit_evt = state == D_SLOT && tmr == 16'(SLOT_DELAY_CYC - 1);
	assign cur_bit = txbusy ? txsh[0] : ln_s2;
	assign hash_bit = bit_evt && !(txbusy && txchk);
	assign byte_end = bit_evt
		&& bitcnt == (txbusy ? txlen - 5'd1 : 5'd7);
	assign data_end = byte_end && !(txbusy && txchk);
	assign chk_sent = byte_end && txbusy && txchk;
	assign por_hit = low_cnt == 16'(POR_CYC - 1);
	assign load_now = state == D_IDLE && !fall && !txbusy
		&& (pend_chk || f_valid);
	assign f_pop = load_now && !pend_chk;

	always_comb begin
		case (chk_sel_in)
			SWL_CHK_EACH:  blk_n = 6'd1;
			SWL_CHK_BLK8:  blk_n = 6'd8;
			SWL_CHK_BLK32: blk_n = 6'd32;
			default:       blk_n = 6'd0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Low-time counter saturates so a stuck line cannot wrap into a reset
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			low_cnt <= '0;
			por_out <= 1'b0;
		end else begin
			low_cnt <= ln_s2 ? '0 : (low_cnt == 16'hffff ? low_cnt
				: low_cnt + 16'd1);
			por_out <= por_hit;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= D_IDLE;
			tmr <= '0;
			link.dev_oe <= 1'b0;
		end else begin
			case (state)
				D_IDLE: begin
					tmr <= '0;
					if (rise && low_cnt >= 16'(RSTL_CYC)) begin
						state <= D_PWAIT;
					end else if (fall) begin
						state <= D_SLOT;
						link.dev_oe <= txbusy && !txsh[0];
					end
				end
				D_SLOT: begin
					tmr <= tmr + 16'd1;
					if (bit_evt) begin
						state <= D_IDLE;
						link.dev_oe <= 1'b0;
					end
				end
				D_PWAIT: begin
					tmr <= tmr + 16'd1;
					if (tmr == 16'(PRESENCE_WAIT_CYC - 1)) begin
						state <= D_PLOW;
						tmr <= '0;
						link.dev_oe <= 1'b1;
					end
				end
				D_PLOW: begin
					tmr <= tmr + 16'd1;
					if (tmr == 16'(PRESENCE_LOW_CYC - 1)) begin
						state <= D_IDLE;
						link.dev_oe <= 1'b0;
					end
				end
				default: begin
					state <= D_IDLE;
					link.dev_oe <= 1'b0;
				end
			endcase
			if (por_hit) begin
				state <= D_IDLE;
				link.dev_oe <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shift paths; a reset pulse drops any half-done byte
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			bitcnt <= '0;
			txbusy <= 1'b0;
			txchk <= 1'b0;
			txlen <= 5'd8;
			txsh <= '0;
			rxsh <= '0;
		end else if (state == D_PWAIT || por_hit) begin
			bitcnt <= '0;
			txbusy <= 1'b0;
		end else if (load_now) begin
			txbusy <= 1'b1;
			bitcnt <= '0;
			if (pend_chk || f_data[9:8] == SWL_KIND_CRC16) begin
				txsh <= ~crc16_out;
				txlen <= 5'd16;
				txchk <= 1'b1;
			end else if (f_data[9:8] == SWL_KIND_CRC8) begin
				txsh <= {8'h00, crc8_out};
				txlen <= 5'd8;
				txchk <= 1'b1;
			end else begin
				txsh <= {8'h00, f_data[7:0]};
				txlen <= 5'd8;
				txchk <= 1'b0;
			end
		end else if (bit_evt) begin
			bitcnt <= byte_end ? '0 : bitcnt + 5'd1;
			txsh <= txsh >> 1;
			rxsh <= {ln_s2, rxsh[7:1]};
			if (byte_end) begin
				txbusy <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_valid_out <= 1'b0;
			rx_data_out <= '0;
		end else begin
			rx_valid_out <= byte_end && !txbusy;
			if (byte_end && !txbusy) begin
				rx_data_out <= {ln_s2, rxsh[7:1]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Check generators run freely; a mismatch never stalls anything
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			crc16_out <= CRC16_CLEAR;
		end else if (crc16_clear_in || chk_sent) begin
			crc16_out <= CRC16_CLEAR;
		end else if (crc16_load_in) begin
			crc16_out <= crc16_load_val_in;
		end else if (hash_bit) begin
			crc16_out <= swl_crc16_bit(crc16_out, cur_bit);
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			crc8_out <= CRC8_CLEAR;
		end else if (crc8_clear_in) begin
			crc8_out <= CRC8_CLEAR;
		end else if (hash_bit) begin
			crc8_out <= swl_crc8_bit(crc8_out, cur_bit);
		end
	end

	// Set wins over the clear when a block ends as a check is loaded
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pend_chk <= 1'b0;
			blkcnt <= '0;
		end else begin
			if (load_now && pend_chk) begin
				pend_chk <= 1'b0;
			end
			if (crc16_clear_in || blk_n == 6'd0) begin
				blkcnt <= '0;
			end else if (data_end) begin
				if (blkcnt + 6'd1 == blk_n) begin
					blkcnt <= '0;
					pend_chk <= 1'b1;
				end else begin
					blkcnt <= blkcnt + 6'd1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			prog_strobe_out <= 1'b0;
			prog_data_out <= '0;
		end else begin
			prog_strobe_out <= vp_s2 && !vp_q;
			if (rx_valid_out) begin
				prog_data_out <= rx_data_out;
			end
		end
	end
endmodule

// ==== shared/swl_pkg.sv ====
package swl_pkg;

	localparam int CLK_MHZ = 10;

	// Device internal slot delay: sample point and read-zero hold
	localparam int SLOT_DELAY_US        = 30;
	localparam int SLOT_DELAY_CYC       = SLOT_DELAY_US * CLK_MHZ;
	localparam int RESET_LOW_TIME_US    = 480;
	localparam int RESET_LOW_CYC        = RESET_LOW_TIME_US * CLK_MHZ;
	localparam int POR_LOW_MS           = 5;
	localparam int POR_LOW_CYC          = POR_LOW_MS * 1000 * CLK_MHZ;
	localparam int PRESENCE_WAIT_TIME_US = 30;
	localparam int PRESENCE_WAIT_CYC    = PRESENCE_WAIT_TIME_US * CLK_MHZ;
	localparam int PRESENCE_LOW_TIME_US = 120;
	localparam int PRESENCE_LOW_CYC     = PRESENCE_LOW_TIME_US * CLK_MHZ;

	// Master side timing
	localparam int SLOT_US              = 70;
	localparam int SLOT_CYC             = SLOT_US * CLK_MHZ;
	localparam int RECOVERY_US          = 5;
	localparam int RECOVERY_CYC         = RECOVERY_US * CLK_MHZ;
	localparam int WRITE1_LOW_US        = 6;
	localparam int WRITE1_LOW_CYC       = WRITE1_LOW_US * CLK_MHZ;
	localparam int WRITE0_LOW_US        = 60;
	localparam int WRITE0_LOW_CYC       = WRITE0_LOW_US * CLK_MHZ;
	localparam int READ_LOW_US          = 3;
	localparam int READ_LOW_CYC         = READ_LOW_US * CLK_MHZ;
	localparam int READ_VALID_WINDOW_US = 15;
	localparam int READ_SAMPLE_US       = 13;
	localparam int READ_SAMPLE_CYC      = READ_SAMPLE_US * CLK_MHZ;
	localparam int RESET_HIGH_US        = 480;
	localparam int RESET_HIGH_CYC       = RESET_HIGH_US * CLK_MHZ;
	localparam int PRESENCE_SAMPLE_US   = 70;
	localparam int PRESENCE_SAMPLE_CYC  = PRESENCE_SAMPLE_US * CLK_MHZ;
	localparam int PROG_PULSE_US        = 480;
	localparam int PROG_PULSE_CYC       = PROG_PULSE_US * CLK_MHZ;

	localparam logic [15:0] CRC16_CLEAR = 16'h0000;
	localparam logic [15:0] CRC16_POLY  = 16'ha001;
	localparam logic [7:0]  CRC8_CLEAR  = 8'h00;
	localparam logic [7:0]  CRC8_POLY   = 8'h8c;

	typedef enum logic [1:0] {
		SWL_CMD_RESET = 2'b00,
		SWL_CMD_WRITE = 2'b01,
		SWL_CMD_READ  = 2'b10,
		SWL_CMD_PROG  = 2'b11
	} swl_cmd_t;

	typedef enum logic [1:0] {
		SWL_KIND_DATA  = 2'b00,
		SWL_KIND_CRC16 = 2'b01,
		SWL_KIND_CRC8  = 2'b10
	} swl_kind_t;

	typedef enum logic [1:0] {
		SWL_CHK_NONE  = 2'b00,
		SWL_CHK_EACH  = 2'b01,
		SWL_CHK_BLK8  = 2'b10,
		SWL_CHK_BLK32 = 2'b11
	} swl_chk_t;

	// Reflected forms: bits enter least significant first
	function automatic logic [15:0] swl_crc16_bit(logic [15:0] c, logic b);
		logic [15:0] s;
		s = c >> 1;
		return (c[0] ^ b) ? (s ^ CRC16_POLY) : s;
	endfunction

	function automatic logic [7:0] swl_crc8_bit(logic [7:0] c, logic b);
		logic [7:0] s;
		s = c >> 1;
		return (c[0] ^ b) ? (s ^ CRC8_POLY) : s;
	endfunction

endpackage

// ==== shared/swl_if.sv ====
`timescale 1ns/100ps
interface swl_if;
	logic mst_oe;
	logic dev_oe;
	logic vpp;
	logic line;

	// Open-drain line with pull-up: low while either end drives
	assign line = !(mst_oe || dev_oe);

	modport device (input line, input vpp, output dev_oe);
	modport master (input line, output mst_oe, output vpp);
endinterface

// ==== verilog/swl_master.sv ====
`timescale 1ns/100ps
module swl_master #(
	parameter int RSTL_CYC = swl_pkg::RESET_LOW_CYC,
	parameter int RSTH_CYC = swl_pkg::RESET_HIGH_CYC,
	parameter int PROG_CYC = swl_pkg::PROG_PULSE_CYC
) (
	input  wire logic              core_clk_in,  // 10 MHz clock
	input  wire logic              rst_in,       // Async reset
	swl_if.master                  link,         // Single-wire line
	input  wire logic              cmd_valid_in, // Command request
	input  wire swl_pkg::swl_cmd_t cmd_in,       // Command
	input  wire logic        [7:0] wdata_in,     // Byte to write
	output logic                   cmd_ready_out, // Idle
	output logic                   done_out,     // Command finished
	output logic             [7:0] rdata_out,    // Byte read/written
	output logic                   presence_out, // Presence seen
	input  wire logic              crc16_clear_in, // Clear own check
	output logic            [15:0] crc16_out     // Own check value
);
	import swl_pkg::*;

	typedef enum logic [2:0] {
		M_IDLE  = 3'b000,
		M_RLOW  = 3'b001,
		M_RHIGH = 3'b010,
		M_SLOT  = 3'b011,
		M_PROG  = 3'b100
	} swl_mst_t;

	swl_mst_t    state;
	logic        ln_s1, ln_s2;
	logic [15:0] tmr;
	logic [2:0]  bitn;
	logic [7:0]  sh;
	logic        rd;
	logic        rbit;
	logic [15:0] low_len;
	logic        slot_end;
	logic        nbit;

	assign low_len = rd ? 16'(READ_LOW_CYC)
		: (sh[0] ? 16'(WRITE1_LOW_CYC) : 16'(WRITE0_LOW_CYC));
	assign slot_end = state == M_SLOT
		&& tmr == 16'(SLOT_CYC + RECOVERY_CYC - 1);
	assign nbit = rd ? rbit : sh[0];

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ln_s1 <= 1'b1;
			ln_s2 <= 1'b1;
		end else begin
			ln_s1 <= link.line;
			ln_s2 <= ln_s1;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= M_IDLE;
			tmr <= '0;
			bitn <= '0;
			sh <= '0;
			rd <= 1'b0;
			rbit <= 1'b1;
			link.mst_oe <= 1'b0;
			link.vpp <= 1'b0;
			cmd_ready_out <= 1'b1;
			done_out <= 1'b0;
			rdata_out <= '0;
			presence_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			tmr <= tmr + 16'd1;
			case (state)
				M_IDLE: begin
					tmr <= '0;
					bitn <= '0;
					if (cmd_valid_in && cmd_ready_out) begin
						cmd_ready_out <= 1'b0;
						rd <= cmd_in == SWL_CMD_READ;
						sh <= cmd_in == SWL_CMD_READ ? 8'hff : wdata_in;
						case (cmd_in)
							SWL_CMD_RESET: begin
								state <= M_RLOW;
								link.mst_oe <= 1'b1;
							end
							// Caller issues this only after checking the value
							SWL_CMD_PROG: begin
								state <= M_PROG;
								link.vpp <= 1'b1;
							end
							default: begin
								state <= M_SLOT;
								link.mst_oe <= 1'b1;
							end
						endcase
					end
				end
				M_RLOW: begin
					// Low time well below 960 us total with recovery
					if (tmr == 16'(RSTL_CYC - 1)) begin
						state <= M_RHIGH;
						tmr <= '0;
						link.mst_oe <= 1'b0;
						presence_out <= 1'b0;
					end
				end
				M_RHIGH: begin
					if (tmr == 16'(PRESENCE_SAMPLE_CYC - 1)) begin
						presence_out <= !ln_s2;
					end
					if (tmr == 16'(RSTH_CYC - 1)) begin
						state <= M_IDLE;
						done_out <= 1'b1;
						cmd_ready_out <= 1'b1;
					end
				end
				M_SLOT: begin
					if (tmr == low_len - 16'd1) begin
						link.mst_oe <= 1'b0;
					end
					// Late inside the valid window, never past it
					if (tmr == 16'(READ_SAMPLE_CYC - 1)) begin
						rbit <= ln_s2;
					end
					if (slot_end) begin
						tmr <= '0;
						sh <= {nbit, sh[7:1]};
						bitn <= bitn + 3'd1;
						if (bitn == 3'd7) begin
							state <= M_IDLE;
							done_out <= 1'b1;
							cmd_ready_out <= 1'b1;
							rdata_out <= {nbit, sh[7:1]};
						end else begin
							link.mst_oe <= 1'b1;
						end
					end
				end
				M_PROG: begin
					if (tmr == 16'(PROG_CYC - 1)) begin
						state <= M_IDLE;
						link.vpp <= 1'b0;
						done_out <= 1'b1;
						cmd_ready_out <= 1'b1;
					end
				end
				default: begin
					state <= M_IDLE;
					link.mst_oe <= 1'b0;
					link.vpp <= 1'b0;
					cmd_ready_out <= 1'b1;
				end
			endcase
		end
	end

	// Caller compares this with the received (inverted) value
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			crc16_out <= CRC16_CLEAR;
		end else if (crc16_clear_in) begin
			crc16_out <= CRC16_CLEAR;
		end else if (slot_end) begin
			crc16_out <= swl_crc16_bit(crc16_out, nbit);
		end
	end
endmodule

// ==== test/swl_link_props.sv ====
`timescale 1ns/100ps
module swl_link_props import swl_pkg::*; #(
	parameter int PROG_CYC = PROG_PULSE_CYC
) (
	input  wire logic core_clk_in, // Clock
	input  wire logic rst_in,      // Async reset
	input  wire logic mst_oe,      // Master pulls low
	input  wire logic dev_oe,      // Device pulls low
	input  wire logic vpp,         // Program voltage on
	input  wire logic line         // Resolved line
);
	int unsigned hicnt;
	int unsigned hcnt;
	int unsigned lcnt;
	int unsigned vcnt;
	logic        in_slot;
	logic        dev_q;

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

///////////////////////////////////////////////////////////////////////////////
	// Run lengths so far; each count holds the cycles before the level drops
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			hicnt <= '0;
			hcnt <= '0;
			lcnt <= '0;
			vcnt <= '0;
		end else begin
			hicnt <= dev_oe ? hicnt + 1 : '0;
			hcnt <= line ? hcnt + 1 : '0;
			lcnt <= mst_oe ? lcnt + 1 : '0;
			vcnt <= vpp ? vcnt + 1 : '0;
		end
	end

	// Device drive that began inside a master low is a read-zero
	// Own edge register: no sampled-value call outside the properties
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			in_slot <= 1'b0;
			dev_q <= 1'b0;
		end else begin
			dev_q <= dev_oe;
			if (dev_oe && !dev_q) begin
				in_slot <= mst_oe;
			end
		end
	end

	sequence s_join;
		$rose(dev_oe) && mst_oe;
	endsequence

	sequence s_lone_fall;
		$fell(line) && !mst_oe;
	endsequence

	sequence s_prog_start;
		!vpp ##1 vpp;
	endsequence

	AST_READ0_LEN: assert property ($fell(dev_oe) && in_slot |->
		hicnt == SLOT_DELAY_CYC) else $error("read zero hold length wrong");
	AST_PRES_LEN: assert property ($fell(dev_oe) && !in_slot |->
		hicnt == PRESENCE_LOW_CYC) else $error("presence length wrong");
	AST_PRES_WAIT: assert property (s_lone_fall |->
		hcnt >= 15 * CLK_MHZ && hcnt <= 60 * CLK_MHZ)
		else $error("presence wait out of range");
	AST_DEV_JOIN: assert property (s_join |-> $past(mst_oe, 2))
		else $error("device drove before slot edge");
	AST_RESET_MAX: assert property (mst_oe |-> lcnt < 960 * CLK_MHZ)
		else $error("master low too long");
	AST_PROG_IDLE: assert property (s_prog_start |-> $past(line))
		else $error("program pulse not from idle");
	AST_PROG_LEN: assert property ($fell(vpp) |-> vcnt == PROG_CYC)
		else $error("program pulse length wrong");
	AST_VPP_EXCL: assert property (vpp |-> !mst_oe && !dev_oe)
		else $error("line pulled low under program voltage");
endmodule

// ==== test/single_wire_slot_crc_engine_tb.sv ====
`timescale 1ns/100ps
`define CHK(a, x) \
	begin \
		total_checks++; \
		if ((a) !== (x)) begin \
			bad_count++; \
			$display("MISMATCH t=%0t got=%h exp=%h", $time, a, x); \
		end \
	end

module single_wire_slot_crc_engine_tb;
	import swl_pkg::*;
	logic        core_clk, rst, cvld, tvld, c16clr, c16ld, c8clr;
	logic        crdy, done, pres, txr, rxv, pst, por, pseen, pors;
	logic [7:0]  wd, td, rdm, rxd, rxl, pdat, c8;
	logic [7:0]  hdr [3];
	logic [15:0] mcrc, dcrc, ldv, e;
	swl_cmd_t    cmd;
	swl_kind_t   kind;
	swl_chk_t    csel;
	int          bad_count, total_checks;

///////////////////////////////////////////////////////////////////////////////
	// Reset and slot lengths stay at full size: a shorter reset count would
	// make every write-zero look like a reset to the device
	swl_if i_swl_if ();
	swl_master i_swl_master (.core_clk_in(core_clk), .rst_in(rst),
		.link(i_swl_if), .cmd_valid_in(cvld), .cmd_in(cmd), .wdata_in(wd),
		.cmd_ready_out(crdy), .done_out(done), .rdata_out(rdm),
		.presence_out(pres), .crc16_clear_in(c16clr), .crc16_out(mcrc));
	swl_device i_swl_device (.core_clk_in(core_clk), .rst_in(rst),
		.link(i_swl_if), .tx_valid_in(tvld), .tx_kind_in(kind),
		.tx_data_in(td), .tx_ready_out(txr), .rx_valid_out(rxv),
		.rx_data_out(rxd), .crc16_clear_in(c16clr), .crc16_load_in(c16ld),
		.crc16_load_val_in(ldv), .crc8_clear_in(c8clr), .chk_sel_in(csel),
		.prog_strobe_out(pst), .prog_data_out(pdat), .por_out(por),
		.crc16_out(dcrc), .crc8_out(c8));
	swl_link_props i_swl_link_props (.core_clk_in(core_clk), .rst_in(rst),
		.mst_oe(i_swl_if.mst_oe), .dev_oe(i_swl_if.dev_oe),
		.vpp(i_swl_if.vpp), .line(i_swl_if.line));

	always @(posedge core_clk) begin
		if (rxv === 1'b1)
			rxl <= rxd;
		if (pst === 1'b1)
			pseen <= 1'b1;
		if (por === 1'b1)
			pors <= 1'b1;
	end

///////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] m16(logic [15:0] c, logic [7:0] b);
		for (int i = 0; i < 8; i++)
			c = (c[0] ^ b[i]) ? ((c >> 1) ^ CRC16_POLY) : (c >> 1);
		return c;
	endfunction

	function automatic logic [7:0] m8(logic [7:0] c, logic [7:0] b);
		for (int i = 0; i < 8; i++)
			c = (c[0] ^ b[i]) ? ((c >> 1) ^ CRC8_POLY) : (c >> 1);
		return c;
	endfunction

	task automatic print_verdict();
		if (bad_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic mcmd(input swl_cmd_t c, input logic [7:0] d);
		int n;
		@(posedge core_clk);
		cvld <= 1'b1;
		cmd <= c;
		wd <= d;
		do @(posedge core_clk); while (crdy !== 1'b1);
		cvld <= 1'b0;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (done !== 1'b1 && n < 20000);
		// A command that never ends is a failure, not a silent skip
		if (done !== 1'b1) begin
			bad_count++;
			print_verdict();
		end
	endtask

	task automatic wr(input logic [7:0] x);
		mcmd(SWL_CMD_WRITE, x);
		`CHK(rxl, x)
	endtask

	task automatic rd(input logic [7:0] x);
		mcmd(SWL_CMD_READ, 8'h00);
		`CHK(rdm, x)
	endtask

	task automatic push(input swl_kind_t k, input logic [7:0] d);
		@(posedge core_clk);
		tvld <= 1'b1;
		kind <= k;
		td <= d;
		do @(posedge core_clk); while (txr !== 1'b1);
		tvld <= 1'b0;
	endtask

	task automatic clears(input logic a16, input logic a8, input logic ld);
		@(posedge core_clk);
		c16clr <= a16;
		c8clr <= a8;
		c16ld <= ld;
		@(posedge core_clk);
		c16clr <= 1'b0;
		c8clr <= 1'b0;
		c16ld <= 1'b0;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	initial begin
		repeat (99000) @(posedge core_clk);
		bad_count++;
		print_verdict();
	end

	initial begin
		{rst, cvld, tvld, c16clr, c16ld, c8clr, pseen, pors} = 8'h80;
		{wd, td, rxl} = '0;
		cmd = SWL_CMD_RESET;
		kind = SWL_KIND_DATA;
		csel = SWL_CHK_NONE;
		ldv = 16'h0013;
		hdr = '{8'hf0, 8'h12, 8'h00};
		bad_count = 0;
		total_checks = 0;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		mcmd(SWL_CMD_RESET, 8'h00);
		`CHK(pres, 1'b1)
		clears(1'b1, 1'b1, 1'b0);
		e = CRC16_CLEAR;
		foreach (hdr[i]) begin
			wr(hdr[i]);
			e = m16(e, hdr[i]);
		end
		push(SWL_KIND_DATA, 8'ha5);
		rd(8'ha5);
		e = m16(e, 8'ha5);
		`CHK(dcrc, e)
		`CHK(mcrc, e)
		push(SWL_KIND_CRC16, 8'h00);
		rd(~e[7:0]);
		rd(~e[15:8]);
		`CHK(dcrc, CRC16_CLEAR)
		// Load first, then shift a byte: the check seeds from the address
		clears(1'b0, 1'b1, 1'b1);
		wr(8'h3c);
		`CHK(dcrc, m16(16'h0013, 8'h3c))
		`CHK(c8, m8(CRC8_CLEAR, 8'h3c))
		push(SWL_KIND_CRC8, 8'h00);
		rd(m8(CRC8_CLEAR, 8'h3c));
		mcmd(SWL_CMD_PROG, 8'h00);
		`CHK(pseen, 1'b1)
		`CHK(pdat, 8'h3c)
		@(posedge core_clk);
		csel <= SWL_CHK_EACH;
		clears(1'b1, 1'b0, 1'b0);
		push(SWL_KIND_DATA, 8'h81);
		rd(8'h81);
		e = m16(CRC16_CLEAR, 8'h81);
		rd(~e[7:0]);
		rd(~e[15:8]);
		// No low period in this run comes near the power-on limit
		`CHK(pors, 1'b0)
		print_verdict();
	end
endmodule
